/* File: pkg/uifc_pkg.sv */
/*
  uifc_pkg: offsets, field positions, reset values, codes and counts for the
  interrupt identification and fifo control block.
  assumes: single clock domain, synchronous active-high reset.
*/
package uifc_pkg;
  // ---------------------------------------------------------------
  // register offsets (register index on the host register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_HOLDING = 4'h0;
  localparam logic [3:0] OFS_INTERRUPT_ENABLE = 4'h1;
  localparam logic [3:0] OFS_INTERRUPT_IDENT = 4'h2;
  localparam logic [3:0] OFS_FIFO_CONTROL = 4'h2;
  localparam logic [3:0] OFS_ENHANCED_FEATURE = 4'h2;
  localparam logic [3:0] OFS_LINE_CONTROL = 4'h3;
  localparam logic [3:0] OFS_DIVISOR_LOW = 4'h0;
  localparam logic [3:0] OFS_DIVISOR_HIGH = 4'h1;
  localparam logic [7:0] LCR_ENHANCED_KEY = 8'hbf;
  localparam int LCR_DLAB_BIT = 7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FC_ENABLE_BIT = 0;
  localparam int FC_RX_RESET_BIT = 1;
  localparam int FC_TX_RESET_BIT = 2;
  localparam int FC_TX_TRIG_LSB = 4;
  localparam int FC_RX_TRIG_LSB = 6;
  localparam int EF_ENHANCED_BIT = 4;
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_READY = 1;
  localparam int IE_LINE_STATUS = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_IDENT = 8'h01;
  localparam logic [7:0] RST_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] RST_ENHANCED_FEATURE = 8'h00;
  localparam logic [7:0] RST_LINE_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIVISOR_LOW = 8'h01;
  localparam logic [7:0] RST_DIVISOR_HIGH = 8'h00;
  // ---------------------------------------------------------------
  // interrupt identification codes, bits [5:0]
  // ---------------------------------------------------------------
  localparam logic [5:0] ID_LINE_STATUS = 6'h06;
  localparam logic [5:0] ID_RX_TIMEOUT = 6'h0c;
  localparam logic [5:0] ID_RX_DATA = 6'h04;
  localparam logic [5:0] ID_TX_READY = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_PIN_CHANGE = 6'h30;
  localparam logic [5:0] ID_XOFF_SPECIAL = 6'h10;
  localparam logic [5:0] ID_FLOW_INACTIVE = 6'h20;
  localparam logic [5:0] ID_NONE = 6'h01;
  // ---------------------------------------------------------------
  // trigger thresholds and depths
  // ---------------------------------------------------------------
  localparam logic [6:0] RX_TRIG_0 = 7'h08;
  localparam logic [6:0] RX_TRIG_1 = 7'h10;
  localparam logic [6:0] RX_TRIG_2 = 7'h38;
  localparam logic [6:0] RX_TRIG_3 = 7'h3c;
  localparam logic [6:0] TX_TRIG_0 = 7'h08;
  localparam logic [6:0] TX_TRIG_1 = 7'h10;
  localparam logic [6:0] TX_TRIG_2 = 7'h20;
  localparam logic [6:0] TX_TRIG_3 = 7'h38;
  localparam logic [6:0] SINGLE_TRIG = 7'h01;
  localparam int FIFO_DEPTH_FULL = 64;
  localparam int STAGE_DEPTH = 16;
endpackage

/* File: rtl/uifc_core.sv */
/*
  uifc_core: interrupt identification and fifo control of one uart channel:
  prioritised interrupt encoding, trigger levels, fifo clears, fifo and
  single-character modes, divisor high byte.
  assumes: read/write strobes on clk_sys;
  serialiser, receiver and flow control sit outside
  and send pulses or levels.
*/
`timescale 1ns/1ps
import uifc_pkg::*;
// Contract
// RQ1 - bit 0 low while enabled interrupt pending
// RQ2 - encode priorities 1 to 4 with codes
// RQ3 - input pin change is priority 5
// RQ4 - xoff or special character is priority 6
// RQ5 - cts/rts going inactive is priority 7
// RQ6 - rx trigger 8, 16, 56, 60
// RQ7 - tx trigger 8, 16, 32, 56 spaces
// RQ8 - bit 2 clears tx fifo, self-clears
// RQ9 - bit 1 clears rx fifo, self-clears
// RQ10 - fifo off: one character, bits locked
// RQ11 - fifo on: 64 characters each way
// RQ12 - tx trigger writable only when enhanced
// RQ13 - upper enable bits writable only when enhanced
// RQ14 - enhanced bit gates upper bits and sleep
// RQ15 - tx ready on empty or space above trigger
// RQ16 - ident bits 7:6 mirror fifo enable
// RQ17 - divisor high cleared by power-on only
// RQ18 - reset: ident 0x01, fifo control 0x00
module uifc_core #(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH_FULL,
  parameter int AW = 6
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [WIDTH-1:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [WIDTH-1:0] tx_data,
  input wire logic line_status_error,
  input wire logic rx_timeout,
  input wire logic modem_event,
  input wire logic pin_change_event,
  input wire logic xoff_special_event,
  input wire logic flow_inactive_event,
  output logic irq_n,
  output logic sleep_allowed,
  output logic [7:0] divisor_low,
  output logic [7:0] divisor_high
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] fifo_control;
  logic [7:0] interrupt_enable;
  logic [7:0] enhanced_feature;
  logic [7:0] line_control;
  logic [7:0] interrupt_ident;
  logic [7:0] next_ident;
  logic tx_flush;
  logic rx_flush;
  logic modem_pend;
  logic pin_pend;
  logic xoff_pend;
  logic flow_pend;
  logic tx_ready_pend;
  logic tx_above_prev;

  logic fifo_on;
  logic enh;
  logic normal_bank;
  logic enh_bank;
  logic wr_ident;
  logic wr_ier;
  logic wr_efr;
  logic wr_lcr;
  logic wr_dll;
  logic wr_dlm;
  logic wr_hold;
  logic rd_hold;
  logic rd_ident;
  logic [AW:0] limit;
  logic [AW:0] rx_level;
  logic [AW:0] tx_level;
  logic [AW:0] tx_space;
  logic [6:0] rx_trig;
  logic [6:0] tx_trig;
  logic rx_above;
  logic tx_above;
  logic hold_in_ready;
  logic host_out_valid;
  logic [WIDTH-1:0] host_out_data;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [6:0] rx_thresh(input logic [1:0] code);
    unique case (code)
      2'b00: rx_thresh = RX_TRIG_0;
      2'b01: rx_thresh = RX_TRIG_1;
      2'b10: rx_thresh = RX_TRIG_2;
      2'b11: rx_thresh = RX_TRIG_3;
    endcase
  endfunction

  function automatic logic [6:0] tx_thresh(input logic [1:0] code);
    unique case (code)
      2'b00: tx_thresh = TX_TRIG_0;
      2'b01: tx_thresh = TX_TRIG_1;
      2'b10: tx_thresh = TX_TRIG_2;
      2'b11: tx_thresh = TX_TRIG_3;
    endcase
  endfunction

  assign fifo_on = fifo_control[FC_ENABLE_BIT];
  assign enh = enhanced_feature[EF_ENHANCED_BIT];
  assign enh_bank = (line_control == LCR_ENHANCED_KEY);
  assign normal_bank = !line_control[LCR_DLAB_BIT];
  assign wr_ident = reg_wr && normal_bank && (reg_addr == OFS_FIFO_CONTROL);
  assign wr_ier = reg_wr && normal_bank && (reg_addr == OFS_INTERRUPT_ENABLE);
  assign wr_hold = reg_wr && normal_bank && (reg_addr == OFS_HOLDING);
  assign rd_hold = reg_rd && normal_bank && (reg_addr == OFS_HOLDING);
  assign rd_ident = reg_rd && normal_bank && (reg_addr == OFS_INTERRUPT_IDENT);
  assign wr_efr = reg_wr && enh_bank && (reg_addr == OFS_ENHANCED_FEATURE);
  assign wr_lcr = reg_wr && (reg_addr == OFS_LINE_CONTROL);
  assign wr_dll = reg_wr && !normal_bank && !enh_bank && (reg_addr == OFS_DIVISOR_LOW);
  assign wr_dlm = reg_wr && !normal_bank && !enh_bank && (reg_addr == OFS_DIVISOR_HIGH);

  // single-character mode: each side holds one, trigger of one
  assign limit = fifo_on ? (AW+1)'(DEPTH) : (AW+1)'(1); // [RQ10] [RQ11]
  assign rx_trig = fifo_on ? rx_thresh(fifo_control[FC_RX_TRIG_LSB +: 2]) : SINGLE_TRIG; // [RQ6] [RQ10]
  assign tx_trig = fifo_on ? tx_thresh(fifo_control[FC_TX_TRIG_LSB +: 2]) : SINGLE_TRIG; // [RQ7] [RQ10]
  assign tx_space = limit - tx_level;
  assign rx_above = (7'(rx_level) >= rx_trig);
  // non-fifo: holding empty is one free space
  assign tx_above = fifo_on ? (7'(tx_space) > tx_trig) : (tx_level == '0); // [RQ15]

  // ---------------------------------------------------------------
  // fifos: rx from the receiver to the host, tx from the host outward
  // ---------------------------------------------------------------
  uifc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clk_sys(clk_sys),
    .reset(reset || soft_reset),
    .flush(rx_flush), // [RQ9]
    .limit(limit),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(host_out_valid),
    .out_ready(rd_hold),
    .out_data(host_out_data),
    .level(rx_level)
  );

  uifc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clk_sys(clk_sys),
    .reset(reset || soft_reset),
    .flush(tx_flush), // [RQ8]
    .limit(limit),
    .in_valid(wr_hold),
    .in_ready(hold_in_ready),
    .in_data(reg_wdata),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .level(tx_level)
  );

  // ---------------------------------------------------------------
  // fifo control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
    begin
      fifo_control <= RST_FIFO_CONTROL; // [RQ18]
    end
    else if (wr_ident)
    begin
      fifo_control[FC_ENABLE_BIT] <= reg_wdata[FC_ENABLE_BIT];
      // other bits locked unless enabling
      if (reg_wdata[FC_ENABLE_BIT])
      begin
        fifo_control[FC_RX_TRIG_LSB +: 2] <= reg_wdata[FC_RX_TRIG_LSB +: 2]; // [RQ10]
        if (enh)
        begin
          fifo_control[FC_TX_TRIG_LSB +: 2] <= reg_wdata[FC_TX_TRIG_LSB +: 2]; // [RQ12] [RQ14]
        end
      end
    end
  end

  // clear pulses; bits 2:1 never stored
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
    begin
      tx_flush <= 1'b0;
      rx_flush <= 1'b0;
    end
    else
    begin
      tx_flush <= wr_ident && reg_wdata[FC_ENABLE_BIT] && reg_wdata[FC_TX_RESET_BIT]; // [RQ8] [RQ10]
      rx_flush <= wr_ident && reg_wdata[FC_ENABLE_BIT] && reg_wdata[FC_RX_RESET_BIT]; // [RQ9] [RQ10]
    end
  end

  // ---------------------------------------------------------------
  // enable, enhanced feature and line control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
    begin
      interrupt_enable <= RST_INTERRUPT_ENABLE;
      enhanced_feature <= RST_ENHANCED_FEATURE;
      line_control <= RST_LINE_CONTROL;
    end
    else
    begin
      if (wr_ier)
      begin
        interrupt_enable[3:0] <= reg_wdata[3:0];
        if (enh)
        begin
          interrupt_enable[7:4] <= reg_wdata[7:4]; // [RQ13] [RQ14]
        end
      end
      if (wr_efr)
      begin
        enhanced_feature <= reg_wdata;
      end
      if (wr_lcr)
      begin
        line_control <= reg_wdata;
      end
    end
  end

  // divisor survives software reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      divisor_low <= RST_DIVISOR_LOW;
      divisor_high <= RST_DIVISOR_HIGH; // [RQ17]
    end
    else
    begin
      if (wr_dll)
      begin
        divisor_low <= reg_wdata;
      end
      if (wr_dlm)
      begin
        divisor_high <= reg_wdata; // [RQ17]
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky sources; set wins over the read that clears them
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
    begin
      modem_pend <= 1'b0;
      pin_pend <= 1'b0;
      xoff_pend <= 1'b0;
      flow_pend <= 1'b0;
      tx_ready_pend <= 1'b0;
      tx_above_prev <= 1'b1;
    end
    else
    begin
      tx_above_prev <= tx_above;
      modem_pend <= modem_event || (modem_pend && !(rd_ident && next_ident[5:0] == ID_MODEM));
      pin_pend <= pin_change_event || (pin_pend && !(rd_ident && next_ident[5:0] == ID_PIN_CHANGE));
      xoff_pend <= xoff_special_event || (xoff_pend && !(rd_ident && next_ident[5:0] == ID_XOFF_SPECIAL));
      flow_pend <= flow_inactive_event || (flow_pend && !(rd_ident && next_ident[5:0] == ID_FLOW_INACTIVE));
      // set on rising crossing; read or write clears
      tx_ready_pend <= (tx_above && !tx_above_prev) ||
        (tx_ready_pend && tx_above && !wr_hold && !(rd_ident && next_ident[5:0] == ID_TX_READY)); // [RQ15]
    end
  end

  // ---------------------------------------------------------------
  // priority encoder
  // ---------------------------------------------------------------
  always_comb
  begin
    next_ident = {fifo_on, fifo_on, ID_NONE}; // [RQ16]
    if (flow_pend && (interrupt_enable[IE_CTS] || interrupt_enable[IE_RTS]))
    begin
      next_ident[5:0] = ID_FLOW_INACTIVE; // [RQ5]
    end
    if (xoff_pend && interrupt_enable[IE_XOFF])
    begin
      next_ident[5:0] = ID_XOFF_SPECIAL; // [RQ4]
    end
    if (pin_pend)
    begin
      next_ident[5:0] = ID_PIN_CHANGE; // [RQ3]
    end
    if (modem_pend && interrupt_enable[IE_MODEM])
    begin
      next_ident[5:0] = ID_MODEM; // [RQ2]
    end
    if (tx_ready_pend && interrupt_enable[IE_TX_READY])
    begin
      next_ident[5:0] = ID_TX_READY; // [RQ2]
    end
    if (rx_above && interrupt_enable[IE_RX_DATA])
    begin
      next_ident[5:0] = ID_RX_DATA; // [RQ2]
    end
    if (rx_timeout && rx_level != '0 && interrupt_enable[IE_RX_DATA])
    begin
      next_ident[5:0] = ID_RX_TIMEOUT; // [RQ2]
    end
    if (line_status_error && interrupt_enable[IE_LINE_STATUS])
    begin
      next_ident[5:0] = ID_LINE_STATUS; // [RQ2] [RQ1]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
    begin
      interrupt_ident <= RST_INTERRUPT_IDENT; // [RQ18]
      irq_n <= 1'b1;
      sleep_allowed <= 1'b0;
    end
    else
    begin
      interrupt_ident <= next_ident;
      irq_n <= next_ident[0]; // [RQ1]
      sleep_allowed <= enh && interrupt_enable[IE_SLEEP] && next_ident[0] &&
        rx_level == '0 && tx_level == '0; // [RQ14]
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (!reg_rd)
      begin
        reg_rdata <= 8'h00;
      end
      else if (enh_bank && reg_addr == OFS_ENHANCED_FEATURE)
      begin
        reg_rdata <= enhanced_feature;
      end
      else if (reg_addr == OFS_LINE_CONTROL)
      begin
        reg_rdata <= line_control;
      end
      else if (!normal_bank && reg_addr == OFS_DIVISOR_LOW)
      begin
        reg_rdata <= divisor_low;
      end
      else if (!normal_bank && reg_addr == OFS_DIVISOR_HIGH)
      begin
        reg_rdata <= divisor_high;
      end
      else if (reg_addr == OFS_INTERRUPT_IDENT)
      begin
        reg_rdata <= interrupt_ident; // [RQ16]
      end
      else if (reg_addr == OFS_INTERRUPT_ENABLE)
      begin
        reg_rdata <= interrupt_enable;
      end
      else if (reg_addr == OFS_HOLDING)
      begin
        // empty fifo reads 0
        reg_rdata <= host_out_valid ? host_out_data : 8'h00;
      end
      else
      begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // uifc_core

/* File: rtl/uifc_fifo.sv */
/*
  uifc_fifo: first-in first-out buffer, valid/ready on both sides, with a
  synchronous flush and a limit input that shrinks the usable depth.
  assumes: one clock; limit is between 1 and DEPTH.
*/
`timescale 1ns/1ps
module uifc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  input wire logic [AW:0] limit,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;
  logic shown;

  // limit caps level for single-character mode
  assign in_ready = (level < limit);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_valid = shown;
  assign next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;

  uifc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(do_wr),
    .wr_addr(wr_ptr),
    .wr_data(in_data),
    .rd_addr(next_rd_ptr),
    .rd_data(out_data)
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // registered read adds a cycle before data show
  always_ff @(posedge clk_sys)
  begin
    if (reset || flush)
    begin
      shown <= 1'b0;
    end
    else
    begin
      shown <= (level - (AW+1)'(do_rd)) != '0;
    end
  end
endmodule // uifc_fifo

/* File: rtl/uifc_mem.sv */
/*
  uifc_mem: small synchronous memory, registered read data.
  assumes: one clock.
*/
`timescale 1ns/1ps
module uifc_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rd_data <= store[rd_addr];
  end
endmodule // uifc_mem

/* File: tb/tb.sv */
/*
  tb: register-port tests of uifc_core against the far-end model.
  assumes: clk_sys 125 MHz, reset sync active high.
*/
`timescale 1ns/1ps
module tb
  import uifc_pkg::*;
;
  logic clk_sys, reset, soft_reset, reg_wr, reg_rd, reg_rvalid, irq_n, sleep_allowed;
  logic rx_valid, rx_ready, tx_valid, tx_ready, line_status_error, rx_timeout;
  logic modem_event, pin_change_event, xoff_special_event, flow_inactive_event;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data, tx_data, divisor_low, divisor_high;
  logic [7:0] rx_goal, tx_goal, rx_cnt, tx_cnt, tx_last;
  logic [6:0] rt [4] = '{RX_TRIG_0, RX_TRIG_1, RX_TRIG_2, RX_TRIG_3};
  logic [6:0] tt [4] = '{TX_TRIG_0, TX_TRIG_1, TX_TRIG_2, TX_TRIG_3};
  logic [7:0] ev [5] = '{8'h00, 8'h30, 8'h10, 8'h20, 8'h01};
  logic [7:0] ec [3] = '{8'h04, 8'h0c, 8'h06};
  int bad_count, n_tests, i, c;
  uifc_core u_uifc_core (.*);
  uifc_far_end u_uifc_far_end (.*);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // one-edge read, bounded wait
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    int k;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    k = 0;
    @(negedge clk_sys);
    while (reg_rvalid !== 1'b1 && k < 4)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 4)
    begin
      bad_count++;
      complete_run();
    end
    else
    begin
      check(reg_rdata, e);
      repeat (2) @(posedge clk_sys);
    end
  endtask
  // move n units on rx (t=0) or tx (t=1)
  task automatic go(input bit t, input logic [7:0] n, input logic [7:0] want);
    logic [7:0] b;
    int k;
    @(posedge clk_sys);
    b = t ? tx_cnt : rx_cnt;
    if (t) tx_goal <= b + n;
    else rx_goal <= b + n;
    for (k = 0; k < 200 && 8'((t ? tx_cnt : rx_cnt) - b) != n; k++) @(negedge clk_sys);
    @(posedge clk_sys);
    if (t) tx_goal <= tx_cnt;
    else rx_goal <= rx_cnt;
    check(8'((t ? tx_cnt : rx_cnt) - b), want);
    repeat (3) @(posedge clk_sys);
  endtask
  // ---------------------------------------------------------------
  // clock and sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    {reset, soft_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 15'h0};
    {line_status_error, rx_timeout, modem_event, pin_change_event, xoff_special_event, flow_inactive_event} = 6'h00;
    {rx_goal, tx_goal, bad_count, n_tests} = '0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rdc(4'h2, 8'h01);
    check(divisor_high, 8'h00);
    wr(4'h3, 8'h80);
    wr(4'h1, 8'h5a);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    @(negedge clk_sys);
    check(divisor_high, 8'h5a);
    $display("test reset and divisor done");
    wr(4'h1, 8'hfd);
    rdc(4'h1, 8'h0d);
    wr(4'h3, 8'hbf);
    wr(4'h2, 8'h10);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'hfd);
    rdc(4'h1, 8'hfd);
    {modem_event, pin_change_event, xoff_special_event, flow_inactive_event} <= 4'hf;
    @(posedge clk_sys);
    {modem_event, pin_change_event, xoff_special_event, flow_inactive_event} <= 4'h0;
    repeat (2) @(negedge clk_sys);
    check(8'(irq_n), 8'h00);
    for (i = 0; i < 5; i++) rdc(4'h2, ev[i]);
    $display("test sticky priority done");
    go(1'b0, 8'h03, 8'h01);
    for (i = 0; i < 3; i++)
    begin
      line_status_error <= (i == 2);
      rx_timeout <= (i > 0);
      rdc(4'h2, ec[i]);
    end
    check(8'(irq_n), 8'h00);
    {line_status_error, rx_timeout} <= 2'b00;
    rdc(4'h0, 8'h5a);
    rdc(4'h2, 8'h01);
    check(8'(sleep_allowed), 8'h01);
    wr(4'h0, 8'ha5);
    wr(4'h1, 8'hff);
    rdc(4'h2, 8'h01);
    go(1'b1, 8'h01, 8'h01);
    check(tx_last, 8'ha5);
    rdc(4'h2, 8'h02);
    rdc(4'h2, 8'h01);
    $display("test level priority done");
    wr(4'h1, 8'h01);
    for (c = 0; c < 4; c++)
    begin
      wr(4'h2, 8'(c << 6) | 8'h03);
      go(1'b0, 8'(rt[c] - 7'h01), 8'(rt[c] - 7'h01));
      rdc(4'h2, 8'hc1);
      go(1'b0, 8'h01, 8'h01);
      rdc(4'h2, 8'hc4);
    end
    go(1'b0, 8'h0a, 8'h04);
    $display("test rx trigger done");
    wr(4'h1, 8'h02);
    for (c = 0; c < 4; c++)
    begin
      wr(4'h2, 8'(c << 4) | 8'h05);
      for (i = 0; i < 64 - tt[c]; i++) wr(4'h0, 8'(i));
      rdc(4'h2, 8'hc1);
      go(1'b1, 8'h01, 8'h01);
      rdc(4'h2, 8'hc2);
    end
    wr(4'h3, 8'hbf);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h05);
    for (i = 0; i < 8; i++) wr(4'h0, 8'(i));
    rdc(4'h2, 8'hc1);
    go(1'b1, 8'h01, 8'h01);
    rdc(4'h2, 8'hc2);
    $display("test tx trigger done");
    complete_run();
  end
endmodule // tb

/* File: tb/uifc_far_end.sv */
/*
  uifc_far_end: receiver and serialiser model run by goal counts.
  assumes: valid/ready links of uifc_core on clk_sys.
*/
`timescale 1ns/1ps
module uifc_far_end (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] rx_goal,
  input wire logic [7:0] tx_goal,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  output logic [7:0] rx_cnt,
  output logic [7:0] tx_cnt,
  output logic [7:0] tx_last
);
  // inverse data while idle
  assign rx_valid = rx_cnt != rx_goal;
  assign rx_data = rx_valid ? rx_cnt ^ 8'h5a : ~(rx_cnt ^ 8'h5a);
  assign tx_ready = tx_cnt != tx_goal;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_cnt <= 8'h00;
      tx_cnt <= 8'h00;
      tx_last <= 8'h00;
    end
    else
    begin
      rx_cnt <= rx_cnt + 8'(rx_valid && rx_ready);
      tx_cnt <= tx_cnt + 8'(tx_valid && tx_ready);
      if (tx_valid && tx_ready)
        tx_last <= tx_data;
    end
  end
endmodule // uifc_far_end

/* File: tb/uifc_monitor.sv */
/*
  uifc_monitor: concurrent checks on the ports of uifc_core.
  assumes: bound to uifc_core, one clock, reset sync active high.
*/
`timescale 1ns/1ps
module uifc_monitor
  import uifc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic line_status_error,
  input wire logic rx_timeout,
  input wire logic irq_n,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_high
);
  // ---------------------------------------------------------------
  // bank and fifo shadows
  // ---------------------------------------------------------------
  logic [7:0] lc_seen;
  logic fifo_on;
  logic id_rd;
  assign id_rd = reg_rd && reg_addr == OFS_INTERRUPT_IDENT && !lc_seen[7] && !soft_reset;
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
      lc_seen <= 8'h00;
    else if (reg_wr && reg_addr == OFS_LINE_CONTROL)
      lc_seen <= reg_wdata;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset || soft_reset)
      fifo_on <= 1'b0;
    else if (reg_wr && reg_addr == OFS_FIFO_CONTROL && !lc_seen[7])
      fifo_on <= reg_wdata[FC_ENABLE_BIT];
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_ident_read;
    id_rd;
  endsequence
  sequence s_answer;
    reg_rvalid && reg_rdata[7:6] == {2{$past(fifo_on)}};
  endsequence
  property p_cause(logic [5:0] code, logic src);
    s_ident_read ##1 reg_rdata[5:0] == code |-> $past(src) || $past(src, 2) || $past(src, 3);
  endproperty
  reset_values_a: assert property ($fell(reset) |-> irq_n && !reg_rvalid && !tx_valid
    && divisor_high == RST_DIVISOR_HIGH && divisor_low == RST_DIVISOR_LOW) else $error("bad reset");
  ident_mirror_a: assert property (s_ident_read and $stable(fifo_on) |=> s_answer)
    else $error("ident 7:6 wrong");
  idle_code_a: assert property (s_ident_read ##1 reg_rdata[0] |-> reg_rdata[5:0] == ID_NONE)
    else $error("idle code wrong");
  irq_match_a: assert property (s_ident_read |=> reg_rdata[0] == $past(irq_n))
    else $error("irq_n mismatch");
  code_legal_a: assert property (s_ident_read |=> reg_rdata[5:0] inside {6'h06, 6'h0c, 6'h04,
    6'h02, 6'h00, 6'h30, 6'h10, 6'h20, 6'h01}) else $error("bad code");
  timeout_cause_a: assert property (p_cause(ID_RX_TIMEOUT, rx_timeout))
    else $error("stray timeout");
  line_cause_a: assert property (p_cause(ID_LINE_STATUS, line_status_error))
    else $error("stray line code");
  single_char_a: assert property (!fifo_on && rx_valid && rx_ready && !reg_wr && !soft_reset |=> !rx_ready)
    else $error("two chars held");
  soft_keep_a: assert property (soft_reset && !reg_wr |=> $stable(divisor_high) && $stable(divisor_low))
    else $error("divisor lost");
  div_write_a: assert property (reg_wr && reg_addr == OFS_DIVISOR_HIGH && lc_seen[7]
    && lc_seen != LCR_ENHANCED_KEY && !soft_reset |=> divisor_high == $past(reg_wdata)) else $error("divisor write");
endmodule // uifc_monitor

bind uifc_core uifc_monitor u_uifc_monitor (.*);
